// file: rtl/pmc_power_ctrl.sv
// Contract
// - Core timing comes from the clock input through a divide-by-two stage.
// - Idle halts instruction execution; registers and RAM keep their contents.
// - Idle ends on chip reset or any enabled interrupt.
// - Power-down stops the oscillator; the requesting instruction is the last.
// - Reset ending power-down reinitialises registers but leaves RAM untouched.
// - External interrupt ending power-down keeps registers and RAM.
// - Wake interrupt is enabled and level; low restarts clock, high completes.
// - After the handler returns, execution continues after the power-down instruction.
// - Reset out of idle: up to two machine cycles run, RAM blocked.
// - Emulation floats port zero, weakly pulls other pins, oscillator runs.
// - Only an ordinary reset leaves emulation mode.
// - Auxiliary bit zero set suppresses the latch strobe on code fetches.
// - Clearing that bit restores normal latch strobe generation.
// - The suppression bit clears on reset and holds until cleared.
// - Strobe and port pin states follow the mode.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"
module pmc_power_ctrl (
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic       rst_pin_i,
   input  wire logic       ext_irq_zero_n_i,
   input  wire logic       ext_irq_one_n_i,
   input  wire logic       ale_pin_i,
   input  wire logic [1:0] irq_enable_i,
   input  wire logic [1:0] irq_level_i,
   input  wire logic       any_irq_i,
   input  wire logic       fetch_ext_i,
   input  wire logic       code_fetch_i,
   input  wire logic       ale_req_i,
   input  wire logic       program_fetch_strobe_req_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   output logic            cpu_halt_o,
   output logic            osc_run_o,
   output logic            sfr_reset_o,
   output logic            ram_block_o,
   output logic            wake_resume_o,
   output logic            emission_reduction_mode_o,
   output logic            ale_o,
   output logic            ale_oe_o,
   output logic            ale_pu_o,
   output logic            program_fetch_strobe_o,
   output logic            program_fetch_strobe_oe_o,
   output logic            program_fetch_strobe_pu_o,
   output logic            p0_float_o,
   output logic            p2_addr_o,
   output logic            ports_pu_o
);
   import pmc_pkg::*;

   pmc_regs_t  state_reg;
   pmc_regs_t  state_next;
   pmc_clk_if  clk_bus ();

   logic rst_s;
   logic irq0_n_s;
   logic irq1_n_s;
   logic ale_pin_s;
   logic wake_lvl;
   logic wr_pwr;
   logic wr_aux;

   pmc_clk_div u_div (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .clk_bus   (clk_bus)
   );

   assign rst_s     = state_reg.sync2[0];
   assign irq0_n_s  = state_reg.sync2[1];
   assign irq1_n_s  = state_reg.sync2[2];
   assign ale_pin_s = state_reg.sync2[3];
   assign wr_pwr    = wr_i & (addr_i == `PMC_ADDR_PWR);
   assign wr_aux    = wr_i & (addr_i == `PMC_ADDR_AUX);

   // Only an enabled, level-sensitive line held low may wake power-down.
   assign wake_lvl = (irq_enable_i[0] & irq_level_i[0] & ~irq0_n_s)
                   | (irq_enable_i[1] & irq_level_i[1] & ~irq1_n_s);

   assign clk_bus.run = (state_reg.st != PMC_ST_PD);

   always_comb begin
      state_next        = state_reg;
      state_next.sync1  = {ale_pin_i, ext_irq_one_n_i, ext_irq_zero_n_i, rst_pin_i};
      state_next.sync2  = state_reg.sync1;
      state_next.wake_p = 1'b0;
      state_next.rdata  = 8'h00;

      // Reset must be seen for whole machine cycles of a running clock.
      if (!rst_s) begin
         state_next.rcnt    = 2'h0;
         state_next.ram_blk = 1'b0;
      end else if (clk_bus.mc_tick && state_reg.rcnt != `PMC_RST_MC) begin
         state_next.rcnt = state_reg.rcnt + 2'h1;
      end

      case (state_reg.st)
         PMC_ST_RESET: begin
            state_next.erm = `PMC_ERM_RESET;
            if (!rst_s) begin
               // The emulator holds the latch pin low across the release.
               state_next.st = ale_pin_s ? PMC_ST_RUN : PMC_ST_ONCE;
            end
         end
         PMC_ST_RUN: begin
            if (state_reg.rcnt == `PMC_RST_MC) begin
               state_next.st = PMC_ST_RESET;
            end else if (wr_pwr && wdata_i[`PMC_PWR_PD_BIT]) begin
               state_next.st = PMC_ST_PD;
            end else if (wr_pwr && wdata_i[`PMC_PWR_IDLE_BIT]) begin
               state_next.st = PMC_ST_IDLE;
            end
         end
         PMC_ST_IDLE: begin
            if (rst_s) begin
               // Execution runs on until the reset count expires, RAM fenced.
               state_next.st      = PMC_ST_RUN;
               state_next.ram_blk = 1'b1;
            end else if (any_irq_i) begin
               state_next.st = PMC_ST_RUN;
            end
         end
         PMC_ST_PD: begin
            if (rst_s || wake_lvl) begin
               state_next.st       = PMC_ST_PD_WAKE;
               state_next.irq_wake = ~rst_s;
            end
         end
         PMC_ST_PD_WAKE: begin
            if (state_reg.rcnt == `PMC_RST_MC) begin
               state_next.st = PMC_ST_RESET;
            end else if (!rst_s && !wake_lvl) begin
               // Registers untouched; the core resumes via its handler.
               state_next.st       = PMC_ST_RUN;
               state_next.wake_p   = state_reg.irq_wake;
               state_next.irq_wake = 1'b0;
            end
         end
         PMC_ST_ONCE: begin
            if (state_reg.rcnt == `PMC_RST_MC) begin
               state_next.st = PMC_ST_RESET;
            end
         end
         default: begin
            state_next.st = PMC_ST_RESET;
         end
      endcase

      if (wr_aux && state_reg.st != PMC_ST_RESET) begin
         state_next.erm = wdata_i[`PMC_AUX_ERM_BIT];
      end

      if (rd_i) begin
         if (addr_i == `PMC_ADDR_AUX) begin
            state_next.rdata[`PMC_AUX_ERM_BIT] = state_reg.erm;
         end else if (addr_i == `PMC_ADDR_PWR) begin
            state_next.rdata[`PMC_PWR_IDLE_BIT] = (state_reg.st == PMC_ST_IDLE);
            state_next.rdata[`PMC_PWR_PD_BIT]   = (state_reg.st == PMC_ST_PD_WAKE);
            state_next.rdata[`PMC_PWR_ONCE_BIT] = (state_reg.st == PMC_ST_ONCE);
         end
      end

      // Pins are registered from the next mode so they track the mode flop.
      state_next.ale      = 1'b1;
      state_next.ale_oe   = 1'b0;
      state_next.ale_pu   = 1'b1;
      state_next.program_fetch_strobe     = 1'b1;
      state_next.program_fetch_strobe_oe  = 1'b1;
      state_next.program_fetch_strobe_pu  = 1'b0;
      state_next.p0_float = 1'b0;
      state_next.p2_addr  = 1'b0;
      state_next.ports_pu = 1'b0;
      case (state_next.st)
         PMC_ST_RUN: begin
            if (state_next.erm && code_fetch_i) begin
               state_next.ale_oe = 1'b0;
               state_next.ale_pu = 1'b1;
            end else begin
               state_next.ale    = ale_req_i;
               state_next.ale_oe = 1'b1;
               state_next.ale_pu = 1'b0;
            end
            state_next.program_fetch_strobe = program_fetch_strobe_req_i;
         end
         PMC_ST_IDLE: begin
            state_next.ale_oe   = 1'b1;
            state_next.ale_pu   = 1'b0;
            state_next.p0_float = fetch_ext_i;
            state_next.p2_addr  = fetch_ext_i;
         end
         PMC_ST_PD, PMC_ST_PD_WAKE: begin
            state_next.ale      = 1'b0;
            state_next.ale_oe   = 1'b1;
            state_next.ale_pu   = 1'b0;
            state_next.program_fetch_strobe     = 1'b0;
            state_next.p0_float = fetch_ext_i;
         end
         PMC_ST_ONCE: begin
            state_next.program_fetch_strobe_oe  = 1'b0;
            state_next.program_fetch_strobe_pu  = 1'b1;
            state_next.p0_float = 1'b1;
            state_next.ports_pu = 1'b1;
         end
         default: begin
            state_next.ale_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg     <= '0;
         state_reg.st  <= PMC_ST_RESET;
         state_reg.erm <= `PMC_ERM_RESET;
         // Synchronisers start with the reset pin asserted and the other lines idle.
         // A zero here would look like a low latch pin and fake an emulation entry.
         state_reg.sync1 <= `PMC_SYNC_RESET;
         state_reg.sync2 <= `PMC_SYNC_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_o                   = state_reg.rdata;
   assign cpu_halt_o                = (state_reg.st == PMC_ST_IDLE)
                                    | (state_reg.st == PMC_ST_PD)
                                    | (state_reg.st == PMC_ST_PD_WAKE);
   assign osc_run_o                 = clk_bus.run;
   assign sfr_reset_o               = (state_reg.st == PMC_ST_RESET);
   assign ram_block_o               = state_reg.ram_blk;
   assign wake_resume_o             = state_reg.wake_p;
   assign emission_reduction_mode_o = state_reg.erm;
   assign ale_o                     = state_reg.ale;
   assign ale_oe_o                  = state_reg.ale_oe;
   assign ale_pu_o                  = state_reg.ale_pu;
   assign program_fetch_strobe_o    = state_reg.program_fetch_strobe;
   assign program_fetch_strobe_oe_o = state_reg.program_fetch_strobe_oe;
   assign program_fetch_strobe_pu_o = state_reg.program_fetch_strobe_pu;
   assign p0_float_o                = state_reg.p0_float;
   assign p2_addr_o                 = state_reg.p2_addr;
   assign ports_pu_o                = state_reg.ports_pu;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   property p_idle_enter;
      state_reg.st == PMC_ST_RUN && state_reg.rcnt != `PMC_RST_MC && wr_pwr
         && wdata_i[`PMC_PWR_IDLE_BIT] && !wdata_i[`PMC_PWR_PD_BIT]
         |=> cpu_halt_o && osc_run_o;
   endproperty
   a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");

   property p_idle_irq_exit;
      state_reg.st == PMC_ST_IDLE && !rst_s && any_irq_i |=> !cpu_halt_o && !ram_block_o;
   endproperty
   a_idle_irq_exit: assert property (p_idle_irq_exit) else $error("idle irq exit");

   property p_pd_enter;
      state_reg.st == PMC_ST_RUN && state_reg.rcnt != `PMC_RST_MC && wr_pwr
         && wdata_i[`PMC_PWR_PD_BIT] |=> !osc_run_o && cpu_halt_o && !clk_bus.mc_tick;
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

   property p_pd_irq_keep;
      state_reg.st == PMC_ST_PD && wake_lvl && !rst_s |=> !sfr_reset_o ##1 !sfr_reset_o;
   endproperty
   a_pd_irq_keep: assert property (p_pd_irq_keep) else $error("irq wake reset regs");

   property p_pd_exit;
      state_reg.st == PMC_ST_PD_WAKE && state_reg.irq_wake && !rst_s && !wake_lvl
         |=> wake_resume_o && !cpu_halt_o ##1 !wake_resume_o;
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit");

   property p_idle_rst;
      state_reg.st == PMC_ST_IDLE && rst_s |=> ram_block_o && !cpu_halt_o;
   endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("idle reset window");

   property p_once_pins;
      state_reg.st == PMC_ST_ONCE |-> p0_float_o && !ale_oe_o && ale_pu_o
         && !program_fetch_strobe_oe_o && ports_pu_o && osc_run_o;
   endproperty
   a_once_pins: assert property (p_once_pins) else $error("emulation pins");

   property p_once_hold;
      state_reg.st == PMC_ST_ONCE && !rst_s |=> state_reg.st == PMC_ST_ONCE;
   endproperty
   a_once_hold: assert property (p_once_hold) else $error("emulation left");

   property p_erm_gate;
      state_reg.st == PMC_ST_RUN && state_reg.erm && code_fetch_i && !wr_i
         && state_reg.rcnt != `PMC_RST_MC |=> !ale_oe_o && ale_pu_o;
   endproperty
   a_erm_gate: assert property (p_erm_gate) else $error("latch not suppressed");

   property p_erm_clear;
      wr_aux && !wdata_i[`PMC_AUX_ERM_BIT] |=> !emission_reduction_mode_o;
   endproperty
   a_erm_clear: assert property (p_erm_clear) else $error("suppress not cleared");

   property p_erm_reset;
      sfr_reset_o |=> !emission_reduction_mode_o;
   endproperty
   a_erm_reset: assert property (p_erm_reset) else $error("suppress kept in reset");

   property p_pd_pins;
      state_reg.st == PMC_ST_PD |-> !ale_o && ale_oe_o && !program_fetch_strobe_o;
   endproperty
   a_pd_pins: assert property (p_pd_pins) else $error("power-down pins");
endmodule : pmc_power_ctrl
`default_nettype wire

// file: rtl/pmc_defs.svh
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_ADDR_PWR      8'h87
`define PMC_ADDR_AUX      8'h8e
`define PMC_AUX_ERM_BIT   0
`define PMC_PWR_IDLE_BIT  0
`define PMC_PWR_PD_BIT    1
`define PMC_PWR_ONCE_BIT  2
`define PMC_RST_MC        2'h2
`define PMC_DIV_LAST      3'h5
`define PMC_ERM_RESET     1'b0
`define PMC_SYNC_RESET    4'hf
`endif

// file: rtl/pmc_pkg.sv
package pmc_pkg;
   typedef enum logic [2:0] {
      PMC_ST_RESET   = 3'h0,
      PMC_ST_RUN     = 3'h1,
      PMC_ST_IDLE    = 3'h3,
      PMC_ST_PD      = 3'h2,
      PMC_ST_PD_WAKE = 3'h6,
      PMC_ST_ONCE    = 3'h5
   } pmc_state_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic       phase;
   } pmc_div_t;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      pmc_state_t st;
      logic [1:0] rcnt;
      logic       erm;
      logic       ram_blk;
      logic       irq_wake;
      logic       wake_p;
      logic [7:0] rdata;
      logic       ale;
      logic       ale_oe;
      logic       ale_pu;
      logic       program_fetch_strobe;
      logic       program_fetch_strobe_oe;
      logic       program_fetch_strobe_pu;
      logic       p0_float;
      logic       p2_addr;
      logic       ports_pu;
   } pmc_regs_t;
endpackage : pmc_pkg

// file: rtl/pmc_clk_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pmc_clk_if;
   logic run;
   logic phase;
   logic mc_tick;
   modport div (input run, output phase, output mc_tick);
   modport user (output run, input phase, input mc_tick);
endinterface : pmc_clk_if
`default_nettype wire

// file: rtl/pmc_clk_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"
module pmc_clk_div (
   input  wire logic clock_i,
   input  wire logic sys_rst_i,
   pmc_clk_if.div    clk_bus
);
   import pmc_pkg::*;

   pmc_div_t div_reg;
   pmc_div_t div_next;

   // The phase flop halves the input, so its duty cycle does not matter.
   always_comb begin
      div_next = div_reg;
      if (clk_bus.run) begin
         div_next.phase = ~div_reg.phase;
         if (div_reg.phase) begin
            div_next.cnt = (div_reg.cnt == `PMC_DIV_LAST) ? 3'h0 : div_reg.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   assign clk_bus.phase   = div_reg.phase;
   assign clk_bus.mc_tick = clk_bus.run & div_reg.phase & (div_reg.cnt == `PMC_DIV_LAST);
endmodule : pmc_clk_div
`default_nettype wire

// file: test/pmc_ext_agent.sv
`timescale 1ns/1ns
`default_nettype none
module pmc_ext_agent (
   input  wire logic clock_i,
   input  wire logic osc_run_i,
   output var logic  rst_pin_o,
   output var logic  irq_zero_n_o,
   output var logic  irq_one_n_o,
   output var logic  ale_pin_o
);
   // Released lines settle at their pull levels: the reset pin is pulled down, the rest up.
   initial begin
      rst_pin_o    = 1'b0;
      irq_zero_n_o = 1'b1;
      irq_one_n_o  = 1'b1;
      ale_pin_o    = 1'b1;
   end

   task automatic hold_reset(input logic emul, input int n);
      @(posedge clock_i);
      ale_pin_o <= ~emul;
      rst_pin_o <= 1'b1;
      repeat (n) @(posedge clock_i);
      rst_pin_o <= 1'b0;
      // For an emulation entry the latch pin stays low past the reset release so the device sees it there.
      repeat (6) @(posedge clock_i);
      ale_pin_o <= 1'b1;
   endtask : hold_reset

   // The wake line is held until the oscillator runs or 200 clocks pass, then for a settle time more.
   task automatic irq_wake(input logic which, input int settle);
      int k;
      @(posedge clock_i);
      if (which) begin
         irq_one_n_o <= 1'b0;
      end else begin
         irq_zero_n_o <= 1'b0;
      end
      for (k = 0; k < 200 && osc_run_i !== 1'b1; k++) @(posedge clock_i);
      repeat (settle) @(posedge clock_i);
      irq_zero_n_o <= 1'b1;
      irq_one_n_o  <= 1'b1;
   endtask : irq_wake
endmodule : pmc_ext_agent
`default_nettype wire

// file: test/power_mode_and_ale_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module power_mode_and_ale_control_bench;
   import pmc_pkg::*;
   logic        clock_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        rst_pin_i, irq0_n, irq1_n, ale_pin_i;
   logic [1:0]  irq_enable_i = 2'h3;
   logic [1:0]  irq_level_i = 2'h3;
   logic        any_irq_i = 1'b0;
   logic        fetch_ext_i = 1'b1;
   logic        code_fetch_i = 1'b0;
   logic        ale_req_i = 1'b1;
   logic        program_fetch_strobe_req_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [7:0]  rdata_o;
   logic        cpu_halt_o, osc_run_o, sfr_reset_o, ram_block_o, wake_resume_o, erm_o;
   logic        ale_o, ale_oe_o, ale_pu_o, pfs_o, pfs_oe_o, pfs_pu_o;
   logic        p0_float_o, p2_addr_o, ports_pu_o;
   logic [7:0]  rd_q[$];
   logic [23:0] pin_q[$];
   logic [23:0] pe;
   logic        chk = 1'b0;
   logic        rd_seen = 1'b0;
   logic [31:0] rng = 32'h3e;
   int          failures = 0;
   int          n_tests = 0;
   int          i;
   wire  [11:0] pin_v = {ram_block_o, ale_pu_o, pfs_pu_o, ports_pu_o, cpu_halt_o, osc_run_o,
                         ale_o, ale_oe_o, pfs_o, pfs_oe_o, p0_float_o, p2_addr_o};

   always #50 clock_i = ~clock_i;

   pmc_power_ctrl pmc_power_ctrl_i (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rst_pin_i(rst_pin_i),
      .ext_irq_zero_n_i(irq0_n), .ext_irq_one_n_i(irq1_n), .ale_pin_i(ale_pin_i),
      .irq_enable_i(irq_enable_i), .irq_level_i(irq_level_i), .any_irq_i(any_irq_i),
      .fetch_ext_i(fetch_ext_i), .code_fetch_i(code_fetch_i), .ale_req_i(ale_req_i),
      .program_fetch_strobe_req_i(program_fetch_strobe_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .cpu_halt_o(cpu_halt_o), .osc_run_o(osc_run_o),
      .sfr_reset_o(sfr_reset_o), .ram_block_o(ram_block_o), .wake_resume_o(wake_resume_o),
      .emission_reduction_mode_o(erm_o), .ale_o(ale_o), .ale_oe_o(ale_oe_o),
      .ale_pu_o(ale_pu_o), .program_fetch_strobe_o(pfs_o),
      .program_fetch_strobe_oe_o(pfs_oe_o), .program_fetch_strobe_pu_o(pfs_pu_o),
      .p0_float_o(p0_float_o), .p2_addr_o(p2_addr_o), .ports_pu_o(ports_pu_o)
   );

   pmc_ext_agent pmc_ext_agent_i (
      .clock_i(clock_i), .osc_run_i(osc_run_o), .rst_pin_o(rst_pin_i),
      .irq_zero_n_o(irq0_n), .irq_one_n_o(irq1_n), .ale_pin_o(ale_pin_i)
   );

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // Read data stand only in the cycle after the strobe, so they are taken exactly there.
   always @(posedge clock_i) begin
      rd_seen <= rd_i;
      if (rd_seen) begin
         check({4'h0, rdata_o}, {4'h0, rd_q.pop_front()});
      end
      if (chk) begin
         pe = pin_q.pop_front();
         check(pin_v & pe[23:12], pe[11:0]);
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
   endtask : rd

   task automatic pins(input logic [11:0] m, input logic [11:0] v);
      pin_q.push_back({m, v});
      @(posedge clock_i);
      chk <= 1'b1;
      @(posedge clock_i);
      chk <= 1'b0;
   endtask : pins

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask : cyc

   // Waits are bounded; the extra nanosecond lets the edge's own updates land first.
   task automatic wait_run;
      int k;
      for (k = 0; k < 200 && sfr_reset_o !== 1'b0; k++) @(posedge clock_i) #1;
      check({11'h0, sfr_reset_o}, 12'h000);
      cyc(2);
   endtask : wait_run

   task automatic wait_wake;
      int k;
      for (k = 0; k < 300 && wake_resume_o !== 1'b1; k++) @(posedge clock_i) #1;
      check({11'h0, wake_resume_o}, 12'h001);
   endtask : wait_wake

   initial begin
      #(100 * 5000);
      failures++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      wait_run();
      rd(8'h8e, 8'h00);
      rd(8'h87, 8'h00);
      rd(8'h55, 8'h00);
      for (i = 0; i < 4; i++) begin
         rng = xs(rng);
         program_fetch_strobe_req_i <= rng[9];
         wr(8'h8e, rng[7:0]);
         rd(8'h8e, {7'h0, rng[0]});
         check({11'h0, erm_o}, {11'h0, rng[0]});
      end
      code_fetch_i <= 1'b1;
      ale_req_i    <= 1'b1;
      wr(8'h8e, 8'h01);
      cyc(3);
      pins(12'h410, 12'h400);
      wr(8'h8e, 8'h00);
      cyc(3);
      pins(12'h030, 12'h030);
      code_fetch_i <= 1'b0;
      wr(8'h8e, 8'h01);
      wr(8'h87, 8'h01);
      cyc(2);
      pins(12'h0ff, 12'h0ff);
      rd(8'h87, 8'h01);
      rd(8'h8e, 8'h01);
      any_irq_i <= 1'b1;
      cyc(3);
      pins(12'h080, 12'h000);
      any_irq_i <= 1'b0;
      wr(8'h87, 8'h02);
      cyc(2);
      pins(12'h0ff, 12'h096);
      rng = xs(rng);
      pmc_ext_agent_i.irq_wake(rng[0], 20);
      wait_wake();
      pins(12'h080, 12'h000);
      rd(8'h8e, 8'h01);
      wr(8'h87, 8'h02);
      cyc(2);
      // A disabled or edge-configured line held low must not restart the oscillator.
      rng = xs(rng);
      {irq_enable_i, irq_level_i} <= rng[1] ? 4'hc : 4'h3;
      pmc_ext_agent_i.irq_wake(rng[0], 2);
      pins(12'h040, 12'h000);
      {irq_enable_i, irq_level_i} <= 4'hf;
      pmc_ext_agent_i.hold_reset(1'b0, 30);
      wait_run();
      rd(8'h8e, 8'h00);
      wr(8'h87, 8'h01);
      fork
         pmc_ext_agent_i.hold_reset(1'b0, 30);
         begin
            cyc(6);
            pins(12'h880, 12'h800);
         end
      join
      wait_run();
      pmc_ext_agent_i.hold_reset(1'b1, 30);
      wait_run();
      pins(12'h756, 12'h742);
      rd(8'h87, 8'h04);
      pmc_ext_agent_i.hold_reset(1'b0, 30);
      wait_run();
      rd(8'h87, 8'h00);
      pins(12'h010, 12'h010);
      cyc(4);
      complete_run();
   end
endmodule : power_mode_and_ale_control_bench
`default_nettype wire
